// file: exc_vectors.sv
// exception delivery for vectors 0..3 plus segment error codes
// assumes the pipeline flags a completed instruction with insn_done
// and that dispatch takes every exc_valid pulse
// Summary of operation
// - segment related exceptions push an error code on handler stack
// - code bit 0 external, bit 1 gate table, bit 2 local table
// - selector index sits above the three flag bits
// - unrelated or null segment references give an all-zero code
// - page fault vector uses its own error code layout
// - code pushed as word or doubleword per gate size
// - interrupt return never pops the error code
// - no error code for external pins or software interrupts
// - divide by zero or overflow raises vector 0 fault, no code
// - divide fault saves faulting pointer, no state change
// - fetch breakpoint and general detect fault, the rest trap
// - vector 1 has no code; cause shown in debug status
// - debug faults save current pointer, traps the next one
// - debug traps wait for instruction or task switch to finish
// - vector 2 from nonmaskable pin or forwarded request
// - nonmaskable taken on boundary, saves next instruction pointer
// - instruction in progress completes before nonmaskable delivery
// - breakpoint instruction traps on vector 3, saves following pointer
// - breakpoint instruction is one byte long
// - software interrupt with operand 3 also raises vector 3
// - breakpoint changes no register or memory itself
module exc_vectors (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        insn_valid,
  input  wire logic        insn_done,
  input  wire logic [31:0] insn_ip,
  input  wire logic [31:0] next_ip,
  input  wire logic        div_zero,
  input  wire logic        div_overflow,
  input  wire logic [6:0]  dbg_cond,
  input  wire logic        dbg_status_clr,
  input  wire logic        nmi_pin,
  input  wire logic        nmi_forward,
  input  wire logic        break_op,
  input  wire logic        soft_int,
  input  wire logic [7:0]  soft_vec,
  input  wire logic        maskable_request_pin,
  input  wire logic [7:0]  pin_vec,
  input  wire logic        seg_req,
  input  wire logic        seg_related,
  input  wire logic [7:0]  seg_vec,
  input  wire logic [12:0] seg_index,
  input  wire logic        seg_gate,
  input  wire logic        seg_local,
  input  wire logic        seg_event,
  input  wire logic        seg_null,
  input  wire logic        gate_dword,
  input  wire logic [31:0] page_fault_code,
  input  wire logic        interrupt_return_op,
  output logic             exc_valid,
  output logic [7:0]       exc_vector,
  output logic             exc_trap,
  output logic             exc_err_valid,
  output logic [31:0]      exc_err_code,
  output logic             exc_err_dword,
  output logic [31:0]      exc_saved_ip,
  output logic             exc_commit,
  output logic             exc_soft,
  output logic [6:0]       debug_status_reg,
  output logic [3:0]       return_pop_words
);

  // ------------------------------------------------------------
  // source selection
  // ------------------------------------------------------------
  exc_pkg::src_t src;
  exc_pkg::src_t src_q;
  logic [6:0]    trap_pend;
  logic [6:0]    trap_bits;
  logic [6:0]    fault_bits;
  logic          nmi_pend;
  logic          nmi_pin_q;
  logic          nmi_set;
  logic          seg_err_valid;
  logic [31:0]   seg_err_code;

  assign fault_bits = insn_valid ? (dbg_cond & exc_pkg::DC_FAULT_MASK)
                                 : 7'h00;
  assign trap_bits  = trap_pend | (dbg_cond & ~exc_pkg::DC_FAULT_MASK);
  // pin is level; only a rising edge is a new request
  assign nmi_set    = (nmi_pin && !nmi_pin_q) || nmi_forward;

  // faults on the current instruction outrank everything that waits
  // for the instruction to complete
  always_comb begin
    src = exc_pkg::SRC_NONE;
    if (|fault_bits) begin
      src = exc_pkg::SRC_DBGF;
    end else if (insn_valid && (div_zero || div_overflow)) begin
      src = exc_pkg::SRC_DIV;
    end else if (seg_req) begin
      src = exc_pkg::SRC_SEG;
    end else if (insn_done && |trap_bits) begin
      src = exc_pkg::SRC_DBGT;
    end else if (insn_done && nmi_pend) begin
      src = exc_pkg::SRC_NMI;
    end else if (insn_done && break_op) begin
      src = exc_pkg::SRC_BREAK;
    end else if (insn_done && soft_int) begin
      src = exc_pkg::SRC_SOFT;
    end else if (insn_done && maskable_request_pin) begin
      src = exc_pkg::SRC_PIN;
    end
  end

  exc_errcode exc_errcode_i (
    .seg_req         (seg_req),
    .seg_related     (seg_related),
    .seg_vec         (seg_vec),
    .seg_index       (seg_index),
    .seg_gate        (seg_gate),
    .seg_local       (seg_local),
    .seg_event       (seg_event),
    .seg_null        (seg_null),
    .page_fault_code (page_fault_code),
    .err_valid       (seg_err_valid),
    .err_code        (seg_err_code)
  );

  // ------------------------------------------------------------
  // pending events
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      trap_pend <= 7'h00;
    end else if (src == exc_pkg::SRC_DBGT) begin
      trap_pend <= 7'h00;
    end else begin
      trap_pend <= trap_bits;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      nmi_pin_q <= 1'b0;
      nmi_pend  <= 1'b0;
    end else begin
      nmi_pin_q <= nmi_pin;
      // a fresh request in the delivery cycle is kept, not merged
      nmi_pend  <= nmi_set ||
                   (nmi_pend && src != exc_pkg::SRC_NMI);
    end
  end

  // ------------------------------------------------------------
  // debug status, sticky until the handler clears it
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      debug_status_reg <= exc_pkg::DSTAT_RESET;
    end else begin
      // set beats clear so no cause is lost
      debug_status_reg <=
        (dbg_status_clr ? exc_pkg::DSTAT_RESET : debug_status_reg)
        | ((src == exc_pkg::SRC_DBGF) ? fault_bits : 7'h00)
        | ((src == exc_pkg::SRC_DBGT) ? trap_bits : 7'h00);
    end
  end

  // ------------------------------------------------------------
  // delivery to dispatch
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      exc_valid     <= 1'b0;
      exc_vector    <= 8'h00;
      exc_trap      <= 1'b0;
      exc_err_valid <= 1'b0;
      exc_err_code  <= exc_pkg::EC_NULL;
      exc_err_dword <= 1'b0;
      exc_saved_ip  <= 32'h0000_0000;
      exc_commit    <= 1'b0;
      exc_soft      <= 1'b0;
      src_q         <= exc_pkg::SRC_NONE;
    end else begin
      src_q         <= src;
      exc_valid     <= src != exc_pkg::SRC_NONE;
      exc_err_valid <= 1'b0;
      exc_err_code  <= exc_pkg::EC_NULL;
      exc_err_dword <= gate_dword;
      exc_soft      <= 1'b0;
      unique case (src)
        exc_pkg::SRC_NONE: begin
          exc_vector   <= exc_vector;
          exc_trap     <= exc_trap;
          exc_saved_ip <= exc_saved_ip;
          exc_commit   <= 1'b0;
        end
        exc_pkg::SRC_DBGF: begin
          exc_vector   <= exc_pkg::VEC_DEBUG;
          exc_trap     <= 1'b0;
          exc_saved_ip <= insn_ip;
          exc_commit   <= 1'b0;
        end
        exc_pkg::SRC_DIV: begin
          exc_vector   <= exc_pkg::VEC_DIVIDE;
          exc_trap     <= 1'b0;
          exc_saved_ip <= insn_ip;
          exc_commit   <= 1'b0;
        end
        exc_pkg::SRC_SEG: begin
          exc_vector    <= seg_vec;
          exc_trap      <= 1'b0;
          exc_saved_ip  <= insn_ip;
          exc_commit    <= 1'b0;
          exc_err_valid <= seg_err_valid;
          exc_err_code  <= seg_err_code;
        end
        exc_pkg::SRC_DBGT: begin
          exc_vector   <= exc_pkg::VEC_DEBUG;
          exc_trap     <= 1'b1;
          exc_saved_ip <= next_ip;
          exc_commit   <= 1'b1;
        end
        exc_pkg::SRC_NMI: begin
          exc_vector   <= exc_pkg::VEC_NMI;
          exc_trap     <= 1'b1;
          exc_saved_ip <= next_ip;
          exc_commit   <= 1'b1;
        end
        exc_pkg::SRC_BREAK: begin
          exc_vector   <= exc_pkg::VEC_BREAK;
          exc_trap     <= 1'b1;
          exc_saved_ip <= insn_ip + exc_pkg::BREAK_LEN;
          exc_commit   <= 1'b0;
        end
        exc_pkg::SRC_SOFT: begin
          exc_vector   <= soft_vec;
          exc_trap     <= 1'b1;
          exc_saved_ip <= next_ip;
          exc_commit   <= 1'b1;
          exc_soft     <= 1'b1;
        end
        exc_pkg::SRC_PIN: begin
          exc_vector   <= pin_vec;
          exc_trap     <= 1'b1;
          exc_saved_ip <= next_ip;
          exc_commit   <= 1'b1;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // return frame size
  // ------------------------------------------------------------
  // the frame popped on return never includes the error code;
  // handlers must discard it themselves
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      return_pop_words <= 4'h0;
    end else if (interrupt_return_op) begin
      return_pop_words <= exc_pkg::FRAME_WORDS;
    end else begin
      return_pop_words <= 4'h0;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  div_fault_a: assert property (
    insn_valid && div_zero && fault_bits == 7'h00
    |=> exc_valid && exc_vector == exc_pkg::VEC_DIVIDE && !exc_trap
        && !exc_err_valid)
    else $error("divide error not raised as vector 0 fault");

  div_ip_a: assert property (
    src_q == exc_pkg::SRC_DIV
    |-> exc_saved_ip == $past(insn_ip) && !exc_commit)
    else $error("divide fault saved wrong pointer or committed");

  dbg_fault_a: assert property (
    insn_valid && dbg_cond[exc_pkg::DC_FETCH]
    |=> exc_vector == exc_pkg::VEC_DEBUG && !exc_trap
        && exc_saved_ip == $past(insn_ip)
        && debug_status_reg[exc_pkg::DC_FETCH])
    else $error("fetch breakpoint not a fault at current pointer");

  dbg_trap_a: assert property (
    src_q == exc_pkg::SRC_DBGT
    |-> exc_trap && !exc_err_valid && exc_saved_ip == $past(next_ip))
    else $error("debug trap class or pointer wrong");

  trap_wait_a: assert property (
    trap_pend != 7'h00 && !insn_done
    |=> src_q != exc_pkg::SRC_DBGT)
    else $error("debug trap delivered before completion");

  dbg_noerr_a: assert property (
    exc_valid && src_q inside {exc_pkg::SRC_DBGF, exc_pkg::SRC_DBGT}
    |-> !exc_err_valid && debug_status_reg != 7'h00)
    else $error("debug exception pushed code or hid its cause");

  nmi_latch_a: assert property (
    nmi_forward |=> nmi_pend)
    else $error("forwarded nonmaskable request lost");

  nmi_boundary_a: assert property (
    src_q == exc_pkg::SRC_NMI
    |-> $past(insn_done) && exc_vector == exc_pkg::VEC_NMI
        && exc_saved_ip == $past(next_ip))
    else $error("nonmaskable taken off boundary");

  break_ip_a: assert property (
    src_q == exc_pkg::SRC_BREAK
    |-> exc_trap && !exc_commit && !exc_err_valid
        && exc_saved_ip == $past(insn_ip) + exc_pkg::BREAK_LEN)
    else $error("breakpoint pointer or class wrong");

  pin_noerr_a: assert property (
    src_q inside {exc_pkg::SRC_SOFT, exc_pkg::SRC_PIN}
    |-> !exc_err_valid)
    else $error("error code pushed for external or soft interrupt");

  null_code_a: assert property (
    seg_req && fault_bits == 7'h00 && !(insn_valid && div_zero)
    && !div_overflow && seg_null && seg_vec != exc_pkg::VEC_PAGE
    |=> exc_err_valid && exc_err_code[15:0] == 16'h0000)
    else $error("null reference did not give null code");

  return_frame_a: assert property (
    interrupt_return_op |=> return_pop_words == exc_pkg::FRAME_WORDS)
    else $error("return frame size wrong");

  div_cov_c:   cover property (src_q == exc_pkg::SRC_DIV);
  trap_cov_c:  cover property (src_q == exc_pkg::SRC_DBGT);
  nmi_cov_c:   cover property (src_q == exc_pkg::SRC_NMI);
  break_cov_c: cover property (src_q == exc_pkg::SRC_BREAK);
  seg_cov_c:   cover property (src_q == exc_pkg::SRC_SEG && exc_err_dword);

endmodule

// file: exc_pkg.sv
// constants shared by the exception delivery unit and its error code former
// assumes a single core clock; nothing here is synthesised on its own
package exc_pkg;

  // ------------------------------------------------------------
  // vector numbers
  // ------------------------------------------------------------
  localparam logic [7:0] VEC_DIVIDE = 8'h00;
  localparam logic [7:0] VEC_DEBUG  = 8'h01;
  localparam logic [7:0] VEC_NMI    = 8'h02;
  localparam logic [7:0] VEC_BREAK  = 8'h03;
  localparam logic [7:0] VEC_PAGE   = 8'h0e;

  // ------------------------------------------------------------
  // error code layout
  // ------------------------------------------------------------
  localparam int EC_EVENT_BIT = 0;
  localparam int EC_GATE_BIT  = 1;
  localparam int EC_LOCAL_BIT = 2;
  localparam int EC_INDEX_LSB = 3;
  localparam int EC_INDEX_W   = 13;
  localparam logic [31:0] EC_NULL = 32'h0000_0000;

  // ------------------------------------------------------------
  // debug conditions, one bit each in the debug status
  // ------------------------------------------------------------
  localparam int DC_FETCH  = 0;
  localparam int DC_DATA   = 1;
  localparam int DC_PORT   = 2;
  localparam int DC_DETECT = 3;
  localparam int DC_STEP   = 4;
  localparam int DC_TASK   = 5;
  localparam int DC_ICE    = 6;
  localparam int DC_COUNT  = 7;
  localparam logic [6:0] DC_FAULT_MASK = 7'h09;
  localparam logic [6:0] DSTAT_RESET   = 7'h00;

  // ------------------------------------------------------------
  // misc counts
  // ------------------------------------------------------------
  localparam logic [31:0] BREAK_LEN   = 32'h0000_0001;
  localparam logic [3:0]  FRAME_WORDS = 4'h3;

  typedef enum logic [3:0] {
    SRC_NONE, SRC_DBGF, SRC_DIV, SRC_SEG, SRC_DBGT,
    SRC_NMI, SRC_BREAK, SRC_SOFT, SRC_PIN
  } src_t;

endpackage

// file: exc_errcode.sv
// error code former for segment related exceptions
// assumes inputs are stable in the cycle the main unit samples them
module exc_errcode (
  input  wire logic        seg_req,
  input  wire logic        seg_related,
  input  wire logic [7:0]  seg_vec,
  input  wire logic [12:0] seg_index,
  input  wire logic        seg_gate,
  input  wire logic        seg_local,
  input  wire logic        seg_event,
  input  wire logic        seg_null,
  input  wire logic [31:0] page_fault_code,
  output logic             err_valid,
  output logic [31:0]      err_code
);

  always_comb begin
    err_valid = seg_req;
    err_code  = exc_pkg::EC_NULL;
    if (seg_vec == exc_pkg::VEC_PAGE) begin
      err_code = page_fault_code;
    end else if (seg_related && !seg_null) begin
      // upper half stays zero: reserved for doubleword pushes
      err_code[exc_pkg::EC_INDEX_LSB +: exc_pkg::EC_INDEX_W] =
        seg_index;
      err_code[exc_pkg::EC_EVENT_BIT] = seg_event;
      err_code[exc_pkg::EC_GATE_BIT] = seg_gate;
      // table flag only has meaning for non-gate references
      err_code[exc_pkg::EC_LOCAL_BIT] =
        seg_local && !seg_gate;
    end
  end

endmodule

// file: pipe_model.sv
// instruction stream model on the pipeline side of the exception unit
// assumes the bench raises eval and retire off the rising clock edge
module pipe_model #(
  parameter logic [31:0] START_IP = 32'h0000_1000
) (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        eval,
  input  wire logic        retire,
  input  wire logic [31:0] len,
  output logic             insn_valid,
  output logic             insn_done,
  output logic [31:0]      insn_ip,
  output logic [31:0]      next_ip
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [31:0] ip;

  // ------------------------------------------------------------
  // program counter, advances only on a completed instruction
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ip <= START_IP;
    end else if (retire) begin
      ip <= ip + len;
    end
  end

  assign insn_valid = eval;
  assign insn_done  = retire;
  // pointers turn to noise outside their qualifier, so a stale latch shows
  assign insn_ip    = (eval || retire) ? ip : ~ip;
  assign next_ip    = retire ? ip + len : ~(ip + len);
endmodule

// file: exc_vectors_tb.sv
// self-checking bench for the exception unit, vectors 0..3 and error codes
// assumes one core clock; the pipeline side is the pipe_model partner
module exc_vectors_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [31:0] START_IP = 32'h0000_1000;
  logic        sys_clk, sys_rst, eval, retire, div_zero, div_overflow;
  logic        insn_valid, insn_done, dbg_status_clr, nmi_pin, nmi_forward;
  logic        break_op, soft_int, maskable_request_pin, seg_req, seg_related;
  logic        seg_gate, seg_local, seg_event, seg_null, gate_dword;
  logic        interrupt_return_op, exc_valid, exc_trap, exc_err_valid;
  logic        exc_err_dword, exc_commit, exc_soft;
  logic [6:0]  dbg_cond, debug_status_reg;
  logic [7:0]  soft_vec, pin_vec, seg_vec, exc_vector;
  logic [12:0] seg_index;
  logic [3:0]  return_pop_words;
  logic [31:0] len, insn_ip, next_ip, page_fault_code;
  logic [31:0] exc_err_code, exc_saved_ip;
  logic [31:0] seed, r, cur_ip, ip_exp, ec;
  int          n_errors, total_checks, i, b;

  pipe_model #(.START_IP(START_IP)) pipe_model_i (
    .sys_clk, .sys_rst, .eval, .retire, .len, .insn_valid, .insn_done,
    .insn_ip, .next_ip);

  exc_vectors exc_vectors_i (
    .sys_clk, .sys_rst, .insn_valid, .insn_done, .insn_ip, .next_ip,
    .div_zero, .div_overflow, .dbg_cond, .dbg_status_clr, .nmi_pin,
    .nmi_forward, .break_op, .soft_int, .soft_vec, .maskable_request_pin,
    .pin_vec, .seg_req, .seg_related, .seg_vec, .seg_index, .seg_gate,
    .seg_local, .seg_event, .seg_null, .gate_dword, .page_fault_code,
    .interrupt_return_op, .exc_valid, .exc_vector, .exc_trap,
    .exc_err_valid, .exc_err_code, .exc_err_dword, .exc_saved_ip,
    .exc_commit, .exc_soft, .debug_status_reg, .return_pop_words);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic dbg_trap(input int k);
    return !(k == exc_pkg::DC_FETCH || k == exc_pkg::DC_DETECT);
  endfunction

  // gate table hits make the local flag meaningless, so it reads 0 then
  function automatic logic [31:0] ec_exp();
    if (seg_vec == exc_pkg::VEC_PAGE) return page_fault_code;
    if (!seg_related || seg_null) return 32'h0;
    return {16'h0, seg_index, seg_local & ~seg_gate, seg_gate, seg_event};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    if (n_errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic idle();
    if (retire === 1'h1) cur_ip = cur_ip + len;
    {eval, retire, div_zero, div_overflow, dbg_cond, dbg_status_clr} = '0;
    {nmi_pin, nmi_forward, break_op, soft_int, maskable_request_pin} = '0;
    {seg_req, seg_related, seg_gate, seg_local, seg_event, seg_null} = '0;
    {soft_vec, pin_vec, seg_vec, seg_index, page_fault_code} = '0;
    {gate_dword, interrupt_return_op} = '0;
  endtask

  task automatic go();
    @(negedge sys_clk);
  endtask

  // answer is checked half a cycle after the taking edge
  task automatic expect_exc(input logic [7:0] v, input logic t,
                            input logic c, input logic [31:0] ip);
    @(negedge sys_clk);
    chk(exc_valid, 1'h1);
    chk(exc_vector, v);
    chk(exc_trap, t);
    chk(exc_err_valid, 1'h0);
    chk(exc_commit, c);
    chk(exc_saved_ip, ip);
    idle();
  endtask

  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end

  initial begin
    #200us;
    n_errors++;
    end_sim();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    seed = 32'h06bf;
    retire = 1'h0;
    len = 32'h1;
    cur_ip = START_IP;
    sys_rst = 1'h1;
    idle();
    repeat (10) @(negedge sys_clk);
    sys_rst = 1'h0;
    chk(exc_valid, 1'h0);
    chk(debug_status_reg, exc_pkg::DSTAT_RESET);
    for (i = 0; i < 4; i++) begin
      go();
      eval = 1'h1;
      div_zero = i[0];
      div_overflow = ~i[0];
      expect_exc(exc_pkg::VEC_DIVIDE, 1'h0, 1'h0,
                 cur_ip);
    end
    for (b = 0; b < exc_pkg::DC_COUNT; b++) begin
      go();
      dbg_cond = 7'h01 << b;
      eval = !dbg_trap(b);
      ip_exp = cur_ip;
      if (dbg_trap(b)) begin
        go();
        idle();
        chk(exc_valid, 1'h0);
        r = rnd();
        go();
        retire = 1'h1;
        len = {28'h0, r[3:0]} + 32'h1;
        ip_exp = cur_ip + len;
      end
      expect_exc(exc_pkg::VEC_DEBUG, dbg_trap(b), dbg_trap(b),
                 ip_exp);
      chk(debug_status_reg, 7'h01 << b);
      go();
      dbg_status_clr = 1'h1;
      go();
      idle();
      chk(debug_status_reg, 7'h00);
    end
    for (i = 0; i < 2; i++) begin
      go();
      nmi_forward = (i == 0);
      nmi_pin = (i == 1);
      go();
      nmi_forward = 1'h0;
      chk(exc_valid, 1'h0);
      go();
      retire = 1'h1;
      len = 32'h3;
      ip_exp = cur_ip + len;
      expect_exc(exc_pkg::VEC_NMI, 1'h1, 1'h1,
                 ip_exp);
    end
    go();
    retire = 1'h1;
    break_op = 1'h1;
    len = 32'h1;
    ip_exp = cur_ip + 32'h1;
    expect_exc(exc_pkg::VEC_BREAK, 1'h1, 1'h0,
               ip_exp);
    for (i = 0; i < 4; i++) begin
      r = rnd();
      go();
      retire = 1'h1;
      len = 32'h2;
      soft_int = (i != 3);
      maskable_request_pin = (i == 3);
      soft_vec = (i == 0) ? exc_pkg::VEC_BREAK
               : (i == 1) ? 8'h0d : r[7:0] | 8'h20;
      pin_vec = exc_pkg::VEC_PAGE;
      @(negedge sys_clk);
      chk(exc_valid, 1'h1);
      chk(exc_vector, soft_int ? soft_vec : pin_vec);
      chk(exc_err_valid, 1'h0);
      chk(exc_soft, soft_int);
      chk(exc_trap, 1'h1);
      chk(exc_commit, 1'h1);
      chk(exc_saved_ip, cur_ip + 32'h2);
      idle();
    end
    for (i = 0; i < 16; i++) begin
      r = rnd();
      go();
      seg_req = 1'h1;
      seg_vec = (i == 1 || r[3:0] == 4'h0) ? exc_pkg::VEC_PAGE
                                           : 8'h0a + r[1:0];
      {seg_event, seg_local, seg_gate, seg_index} = r[23:8];
      seg_null = (r[26:24] == 3'h0);
      seg_related = (r[29:27] != 3'h0);
      gate_dword = r[30];
      page_fault_code = rnd();
      // gate hit with the local flag up: the flag must read back as 0
      if (i == 0) begin
        {seg_vec, seg_related, seg_null, seg_gate, seg_local} = {8'h0d, 4'hb};
        {seg_event, seg_index} = {1'h0, 13'h5};
      end
      ec = ec_exp();
      @(negedge sys_clk);
      chk(exc_valid, 1'h1);
      chk(exc_vector, seg_vec);
      chk(exc_err_valid, 1'h1);
      chk(exc_err_code, ec);
      chk(exc_err_dword, gate_dword);
      idle();
    end
    go();
    interrupt_return_op = 1'h1;
    go();
    idle();
    chk(return_pop_words, exc_pkg::FRAME_WORDS);
    go();
    chk(return_pop_words, 4'h0);
    end_sim();
  end
endmodule
